// file: serial_register_port.sv
// Purpose: four-wire serial port giving a host access to core registers
// Assumes: core answers reg_rdata/reg_nbytes for reg_addr in one cycle
// Notes:   shift logic runs on sclk, core handshake on sys_clk
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - after reset or chip select falling, port waits for a command byte
// - command byte: top bit is direction, low six bits register address
// - top bit one means write; data shifts in from next falling edge
// - top bit zero means read; data drives out from next rising edge
// - input bits sampled on serial clock falling edges, not master clock
// - during read, output enabled and one bit driven per rising edge
// - transfer ends after register's last bit; back to command wait
// - chip select high holds port in reset, in command wait
// - chip select rising aborts transfer and floats data output at once
// - a partly shifted write byte is never committed
// - completed read floats data output on last clock pulse falling edge
// - write data goes to registers bytewise; bytes need 4 us spacing
// - up to three bytes, first byte most significant, right-justified
// - addressed register copied whole into shifter before read starts
// - six-bit checksum restarts from the first read bit, on the edge that drives it
// - each driven read bit adds to checksum, giving ones count
// - reading checksum register yields ones count of that value
// - while analog suspend set, waveform samples are forced to zero
// - master clock held static halts all core-side activity
module serial_register_port (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic [5:0]       reg_addr,
  output logic             reg_rd_strobe,
  input  wire logic [23:0] reg_rdata,
  input  wire logic [1:0]  reg_nbytes,
  output logic             reg_wr_en,
  output logic [1:0]       reg_wr_lane,
  output logic [7:0]       reg_wr_data,
  output logic [5:0]       read_ones_count,
  output logic             write_too_fast,
  input  wire logic        analog_suspend_bit,
  input  wire logic [23:0] wave_in,
  output logic [23:0]      wave_out
);

  // link side: framing and read shifter cleared by device reset or chip select high; event toggles, their data and checksum by device reset only
  logic                        link_rst_n;
  serial_port_pkg::port_state_t state;
  logic [4:0]                  bitcnt;
  logic [6:0]                  cmd_sr;
  logic [6:0]                  wr_sr;
  logic                        cmd_dir;
  logic [5:0]                  cmd_addr;
  logic                        req_tog;
  logic [7:0]                  wr_byte;
  logic [1:0]                  wr_idx;
  logic                        wr_tog;
  logic                        loaded;
  logic                        drive_on;
  logic [22:0]                 rd_sr;
  logic [5:0]                  checksum;
  logic [23:0]                 first_word;
  logic [4:0]                  data_last;

  // core side
  logic [2:0]  req_sync;
  logic [2:0]  wr_sync;
  logic        req_pulse;
  logic        wr_pulse;
  logic        fetch_d;
  logic [23:0] snap_data;
  logic [1:0]  snap_nbytes;
  logic [9:0]  commit_cnt;

  assign link_rst_n = reset_n & ~cs_n;
  // the ones count always answers as a single byte, whatever the core says
  assign data_last  = serial_port_pkg::last_bit(
    (cmd_addr == serial_port_pkg::CHECKSUM_ADDR) ? 2'h1 : snap_nbytes);

  // framing state machine, clocked on falling edges
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state  <= serial_port_pkg::ST_CMD;
      bitcnt <= 5'h00;
      cmd_sr <= 7'h00;
      wr_sr  <= 7'h00;
    end else begin
      unique case (state)
        serial_port_pkg::ST_CMD: begin
          if (bitcnt == serial_port_pkg::CMD_LAST_BIT) begin
            bitcnt <= 5'h00;
            if (cmd_sr[6]) begin
              state <= serial_port_pkg::ST_WRITE;
            end else begin
              state <= serial_port_pkg::ST_READ;
            end
          end else begin
            cmd_sr <= {cmd_sr[5:0], din};
            bitcnt <= bitcnt + 5'h01;
          end
        end
        serial_port_pkg::ST_WRITE: begin
          wr_sr <= {wr_sr[5:0], din};
          if (bitcnt == data_last) begin
            state  <= serial_port_pkg::ST_CMD;
            bitcnt <= 5'h00;
          end else begin
            bitcnt <= bitcnt + 5'h01;
          end
        end
        serial_port_pkg::ST_READ: begin
          if (bitcnt == data_last) begin
            state  <= serial_port_pkg::ST_CMD;
            bitcnt <= 5'h00;
          end else begin
            bitcnt <= bitcnt + 5'h01;
          end
        end
      endcase
    end
  end

  // event toggles and their data survive chip select so no edge is faked
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_dir  <= 1'b0;
      cmd_addr <= 6'h00;
      req_tog  <= 1'b0;
      wr_byte  <= 8'h00;
      wr_idx   <= 2'h0;
      wr_tog   <= 1'b0;
    end else begin
      if (link_rst_n && state == serial_port_pkg::ST_CMD &&
          bitcnt == serial_port_pkg::CMD_LAST_BIT) begin
        cmd_dir  <= cmd_sr[6];
        cmd_addr <= {cmd_sr[4:0], din};
        req_tog  <= ~req_tog;
      end
      // only a byte whose eighth bit arrived is handed on
      if (link_rst_n && state == serial_port_pkg::ST_WRITE &&
          bitcnt[2:0] == serial_port_pkg::BYTE_LAST_BIT) begin
        wr_byte <= {wr_sr, din};
        wr_idx  <= bitcnt[4:3];
        wr_tog  <= ~wr_tog;
      end
    end
  end

  // first read word: the checksum answers at its own address
  always_comb begin
    first_word = serial_port_pkg::left_justify(snap_data, snap_nbytes);
    if (cmd_addr == serial_port_pkg::CHECKSUM_ADDR) begin
      first_word = serial_port_pkg::left_justify({18'h00000, checksum},
                                                 2'h1);
    end
  end

  // read shifter, clocked on rising edges
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      loaded   <= 1'b0;
      drive_on <= 1'b0;
      rd_sr    <= 23'h000000;
      dout     <= 1'b0;
    end else if (state == serial_port_pkg::ST_READ) begin
      drive_on <= 1'b1;
      if (!loaded) begin
        loaded <= 1'b1;
        dout   <= first_word[23];
        rd_sr  <= first_word[22:0];
      end else begin
        dout   <= rd_sr[22];
        rd_sr  <= {rd_sr[21:0], 1'b0};
      end
    end else begin
      loaded   <= 1'b0;
      drive_on <= 1'b0;
    end
  end

  // ones count of the read word, kept across chip select
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      checksum <= serial_port_pkg::CSUM_RESET;
    end else if (link_rst_n && state == serial_port_pkg::ST_READ) begin
      if (!loaded) begin
        checksum <= {5'h00, first_word[23]};
      end else begin
        checksum <= checksum + {5'h00, rd_sr[22]};
      end
    end
  end

  // floats at once on chip select rising or the last falling edge
  assign dout_oe = drive_on & (state == serial_port_pkg::ST_READ);

  // toggle synchronisers into the master clock domain
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_sync <= 3'h0;
      wr_sync  <= 3'h0;
    end else begin
      req_sync <= {req_sync[1:0], req_tog};
      wr_sync  <= {wr_sync[1:0], wr_tog};
    end
  end

  assign req_pulse = req_sync[2] ^ req_sync[1];
  assign wr_pulse  = wr_sync[2] ^ wr_sync[1];

  // command taken: present address, then capture the whole register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_addr        <= 6'h00;
      reg_rd_strobe   <= 1'b0;
      fetch_d         <= 1'b0;
      snap_data       <= serial_port_pkg::WORD_RESET;
      snap_nbytes     <= 2'h1;
      read_ones_count <= serial_port_pkg::CSUM_RESET;
    end else begin
      fetch_d       <= req_pulse;
      reg_rd_strobe <= req_pulse & ~cmd_dir;
      if (req_pulse) begin
        reg_addr        <= cmd_addr;
        read_ones_count <= checksum;
      end
      if (fetch_d) begin
        snap_data <= reg_rdata;
        if (reg_nbytes == 2'h0) begin
          snap_nbytes <= 2'h1;
        end else begin
          snap_nbytes <= reg_nbytes;
        end
      end
    end
  end

  // one byte at a time into the core, most significant lane first
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_wr_en   <= 1'b0;
      reg_wr_lane <= 2'h0;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_en <= wr_pulse;
      if (wr_pulse) begin
        reg_wr_data <= wr_byte;
        reg_wr_lane <= snap_nbytes - 2'h1 - wr_idx;
      end
    end
  end

  // byte spacing watch: flags a byte that lands inside the commit window
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      commit_cnt     <= 10'h000;
      write_too_fast <= 1'b0;
    end else begin
      if (wr_pulse) begin
        commit_cnt <= serial_port_pkg::COMMIT_LOAD;
      end else if (commit_cnt != 10'h000) begin
        commit_cnt <= commit_cnt - 10'h001;
      end
      if (wr_pulse && commit_cnt != 10'h000) begin
        write_too_fast <= 1'b1;
      end else if (req_pulse) begin
        write_too_fast <= 1'b0;
      end
    end
  end

  // halts with a static master clock; suspend blanks the samples
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wave_out <= serial_port_pkg::WORD_RESET;
    end else if (analog_suspend_bit) begin
      wave_out <= serial_port_pkg::WORD_RESET;
    end else begin
      wave_out <= wave_in;
    end
  end

  property p_cmd_leaves;
    @(negedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_CMD && bitcnt == 5'h07)
      |=> (state != serial_port_pkg::ST_CMD && bitcnt == 5'h00);
  endproperty
  a_cmd_leaves: assert property (p_cmd_leaves)
    else $error("command byte did not end after eight bits");

  property p_write_dir;
    @(negedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_CMD && bitcnt == 5'h07 && cmd_sr[6])
      |=> (state == serial_port_pkg::ST_WRITE && cmd_dir);
  endproperty
  a_write_dir: assert property (p_write_dir)
    else $error("write command did not enter write phase");

  property p_read_dir;
    @(negedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_CMD && bitcnt == 5'h07 && !cmd_sr[6])
      |=> (state == serial_port_pkg::ST_READ && !cmd_dir);
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("read command did not enter read phase");

  property p_write_end;
    @(negedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_WRITE && bitcnt == data_last)
      |=> (state == serial_port_pkg::ST_CMD);
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write did not return to command wait");

  property p_read_float;
    @(negedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_READ && bitcnt == data_last)
      |=> !dout_oe;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("output still driven after last read bit");

  property p_drive_read;
    @(posedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_READ) ##1
      (state == serial_port_pkg::ST_READ) |-> dout_oe;
  endproperty
  a_drive_read: assert property (p_drive_read)
    else $error("output not driven during read");

  property p_csum_clear;
    @(posedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_READ && !loaded)
      |=> (checksum == {5'h00, dout});
  endproperty
  a_csum_clear: assert property (p_csum_clear)
    else $error("checksum not restarted at first read bit");

  property p_csum_add;
    @(posedge sclk) disable iff (!link_rst_n)
      (state == serial_port_pkg::ST_READ && loaded)
      |=> (checksum == $past(checksum) + {5'h00, dout});
  endproperty
  a_csum_add: assert property (p_csum_add)
    else $error("checksum did not add the driven bit");

  property p_snap;
    @(posedge sys_clk) disable iff (!reset_n)
      req_pulse |=> ##1 (snap_data == $past(reg_rdata));
  endproperty
  a_snap: assert property (p_snap)
    else $error("register word not captured after command");

  property p_suspend;
    @(posedge sys_clk) disable iff (!reset_n)
      analog_suspend_bit |=> (wave_out == 24'h000000);
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("samples not zero under analog suspend");

  property p_wr_commit;
    @(posedge sys_clk) disable iff (!reset_n)
      wr_pulse |=> (reg_wr_en && reg_wr_data == $past(wr_byte));
  endproperty
  a_wr_commit: assert property (p_wr_commit)
    else $error("write byte not presented to the core");

endmodule : serial_register_port
`default_nettype wire

// file: serial_port_pkg.sv
// Purpose: shared constants and types for the serial register port
// Assumes: 250 MHz system clock, registers of one to three bytes
// Notes:   byte counts from the core are 1..3, a 0 is read as 1
`default_nettype none
package serial_port_pkg;

  localparam int CMD_BITS       = 8;
  localparam int ADDR_BITS      = 6;
  localparam int WORD_BYTES     = 3;
  localparam int WORD_BITS      = 24;
  localparam int CSUM_BITS      = 6;
  localparam int CNT_BITS       = 5;
  localparam int CMD_DIR_POS    = 7;

  // address at which the read ones count answers
  localparam logic [5:0] CHECKSUM_ADDR = 6'h3e;

  localparam logic [4:0]  CMD_LAST_BIT  = 5'h07;
  localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;
  localparam logic [23:0] WORD_RESET    = 24'h000000;
  localparam logic [5:0]  CSUM_RESET    = 6'h00;

  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int BYTE_COMMIT_NS    = 4000;
  localparam int BYTE_COMMIT_CYCLES =
    (BYTE_COMMIT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [9:0] COMMIT_LOAD = 10'(BYTE_COMMIT_CYCLES);

  typedef enum logic [2:0] {
    ST_CMD   = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } port_state_t;

  // index of the final bit of a data phase of n bytes
  function automatic logic [4:0] last_bit(input logic [1:0] nbytes);
    logic [4:0] r;
    r = 5'h07;
    unique case (nbytes)
      2'h2:    r = 5'h0f;
      2'h3:    r = 5'h17;
      default: r = 5'h07;
    endcase
    return r;
  endfunction : last_bit

  // move a right-justified word to the top of the 24-bit shifter
  function automatic logic [23:0] left_justify(input logic [23:0] w,
                                               input logic [1:0]  nbytes);
    logic [23:0] r;
    r = w;
    unique case (nbytes)
      2'h2:    r = {w[15:0], 8'h00};
      2'h3:    r = w;
      default: r = {w[7:0], 16'h0000};
    endcase
    return r;
  endfunction : left_justify

endpackage : serial_port_pkg
`default_nettype wire

// file: serial_host.sv
// Purpose: host model that drives the four-wire serial port
// Assumes: sclk idles high between frames, 160 ns period
// Notes:   abort_at below the bit total raises chip select early
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  task automatic xfer(input logic [7:0] cmd, input int nb,
                      input logic [23:0] wd, input int gap,
                      input int abort_at, output logic [23:0] rd);
    int total;
    total = 8 + 8 * nb;
    rd = 24'h000000;
    #7;
    cs_n = 1'b0;
    #80;
    for (int k = 0; k < total; k++) begin
      if (k == abort_at) break;
      // later write bytes are spaced out by gap
      if (k > 8 && k % 8 == 0) #(gap);
      din = (k < 8) ? cmd[7 - k] : wd[8 * nb - 1 - (k - 8)];
      #40;
      sclk = 1'b0;
      #80;
      sclk = 1'b1;
      #40;
      if (k >= 7 && k < total - 1) rd = {rd[22:0], sdo};
    end
    cs_n = 1'b1;
    // idle gap covers transfer spacing and write-to-read spacing
    #4000;
  endtask : xfer
endmodule : serial_host
`default_nettype wire

// file: serial_register_port_tb.sv
// Purpose: self-checking bench for the serial register port
// Assumes: bench plays the core register file behind the port
// Notes:   released data line shows the inverse of the last bit
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin \
  err_total++; $display("Error at %0t got %h expected %h", \
  $time, (g), (x)); end end
module serial_register_port_tb;
  logic        sys_clk, reset_n, sclk, cs_n, din, dout, dout_oe, sdo;
  logic [5:0]  reg_addr, read_ones_count;
  logic        reg_rd_strobe, reg_wr_en, write_too_fast;
  logic [23:0] reg_rdata, wave_in, wave_out, wexp;
  logic [1:0]  reg_nbytes, reg_wr_lane;
  logic [7:0]  reg_wr_data;
  logic        analog_suspend_bit, wchk;
  logic [23:0] mem [64];
  int          len [64];
  logic [15:0] exp_q [$];
  logic [15:0] w;
  int          err_total, checks_done, rs_cnt;
  logic        oe_watch;

  assign reg_rdata  = mem[reg_addr];
  assign reg_nbytes = 2'(len[reg_addr]);
  assign sdo        = dout_oe ? dout : ~dout;

  serial_register_port u_serial_register_port (
    .sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .reg_addr(reg_addr),
    .reg_rd_strobe(reg_rd_strobe), .reg_rdata(reg_rdata),
    .reg_nbytes(reg_nbytes), .reg_wr_en(reg_wr_en),
    .reg_wr_lane(reg_wr_lane), .reg_wr_data(reg_wr_data),
    .read_ones_count(read_ones_count), .write_too_fast(write_too_fast),
    .analog_suspend_bit(analog_suspend_bit), .wave_in(wave_in),
    .wave_out(wave_out)
  );

  serial_host u_serial_host (
    .sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [23:0] msk(input int n);
    return 24'((64'h1 << (8 * n)) - 64'h1);
  endfunction : msk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic rd(input logic [5:0] a, input int n,
                    output logic [23:0] v);
    int c0;
    c0 = rs_cnt;
    u_serial_host.xfer({2'b00, a}, n, 24'h000000, 0, 99, v);
    `CHK(rs_cnt, c0 + 1)
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [23:0] d,
                    input int gap, input int ab);
    logic [23:0] v;
    int n;
    int c0;
    c0 = rs_cnt;
    n = len[a];
    for (int b = 0; b < n; b++)
      if (ab >= 16 + 8 * b)
        exp_q.push_back({a, 2'(n - 1 - b), d[8 * (n - 1 - b) +: 8]});
    u_serial_host.xfer({2'b10, a}, n, d, gap, ab, v);
    `CHK(rs_cnt, c0)
  endtask : wr

  // read strobes seen by the core, one per read command
  always @(posedge sys_clk) begin
    if (reg_rd_strobe === 1'b1) rs_cnt++;
  end

  // a finished read has floated the line before chip select rises
  always @(posedge cs_n) begin
    if (oe_watch === 1'b1) `CHK(dout_oe, 1'b0)
  end

  // core register file model: one byte lane per write pulse
  always @(posedge sys_clk) begin
    if (reg_wr_en === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        w = exp_q.pop_front();
        `CHK({reg_addr, reg_wr_lane, reg_wr_data}, w)
        mem[w[15:10]][8 * w[9:8] +: 8] = w[7:0];
      end
    end
  end

  always @(posedge sys_clk) begin
    if (wchk) `CHK(wave_out, wexp)
    wexp = analog_suspend_bit ? 24'h000000 : wave_in;
    wave_in <= 24'($urandom);
    analog_suspend_bit <= wchk ? 1'($urandom) : 1'b0;
  end

  initial begin
    #390000;
    err_total++;
    end_of_test();
  end

  initial begin
    logic [23:0] v, e;
    logic [5:0]  a;
    int          cnt, pc;
    err_total = 0;
    checks_done = 0;
    reset_n = 1'b0;
    wchk = 1'b0;
    oe_watch = 1'b0;
    void'($urandom(14962));
    for (int i = 0; i < 64; i++) begin
      mem[i] = 24'($urandom);
      len[i] = $urandom_range(1, 3);
    end
    len[5] = 3;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_serial_host.xfer(8'h05, 3, 24'h000000, 0, 12, v);
    `CHK(dout_oe, 1'b0)
    oe_watch = 1'b1;
    pc = -1;
    for (int i = 0; i < 5; i++) begin
      a = 6'($urandom_range(0, 60));
      e = mem[a] & msk(len[a]);
      if (i == 0) fork
        #1500 mem[a] = ~mem[a];
      join_none
      rd(a, len[a], v);
      `CHK(v, e)
      `CHK(dout_oe, 1'b0)
      if (pc >= 0) `CHK(read_ones_count, 6'($countones(pc)))
      cnt = $countones(e);
      rd(serial_port_pkg::CHECKSUM_ADDR, 1, v);
      `CHK(v, 24'(cnt))
      `CHK(read_ones_count, 6'(cnt))
      pc = cnt;
    end
    $display("test reads done");
    for (int i = 0; i < 4; i++) begin
      a = (i == 3) ? 6'h05 : 6'($urandom_range(0, 60));
      wr(a, 24'($urandom), 4000, (i == 3) ? 20 : 99);
      `CHK(write_too_fast, 1'b0)
      `CHK(exp_q.size(), 0)
      rd(a, len[a], v);
      `CHK(v, mem[a] & msk(len[a]))
    end
    $display("test writes done");
    wr(6'h05, 24'($urandom), 0, 99);
    `CHK(write_too_fast, 1'b1)
    rd(6'h05, 3, v);
    `CHK(write_too_fast, 1'b0)
    `CHK(v, mem[5])
    len[61] = 0;
    rd(6'h3d, 1, v);
    `CHK(v, mem[61] & msk(1))
    $display("test fast write done");
    @(posedge sys_clk);
    wchk <= 1'b1;
    repeat (200) @(posedge sys_clk);
    wchk <= 1'b0;
    $display("test suspend done");
    end_of_test();
  end
endmodule : serial_register_port_tb
`default_nettype wire
